// ---- include/sspw_defines.svh ----
// register map, field positions, reset values and timing counts of the strobed serial port
`ifndef SSPW_DEFINES_SVH
`define SSPW_DEFINES_SVH
`define SSPW_ADDR_CTRL1 8'h0e
`define SSPW_ADDR_CTRL2 8'h0f
`define SSPW_ADDR_FDI 8'h10
`define SSPW_ADDR_WDOG 8'h11
`define SSPW_ADDR_TXP 8'h12
`define SSPW_ADDR_RXP 8'h13
`define SSPW_CTRL1_RST 8'h80
`define SSPW_CTRL2_RST 8'h00
`define SSPW_FDI_RST 8'h00
`define SSPW_WDOG_RST 8'h00
`define SSPW_TXP_RST 8'h00
`define SSPW_RXP_RST 8'h00
`define SSPW_CTRL1_MASK 8'he7
`define SSPW_CTRL2_MASK 8'hbc
`define SSPW_FDI_MASK 8'h7f
`define SSPW_WDOG_MASK 8'h1f
`define SSPW_TXP_MASK 8'h0f
`define SSPW_RXP_MASK 8'hff
`define SSPW_CTRL1_PD 7
`define SSPW_CTRL1_RXMUTE 1
`define SSPW_CTRL1_TXMUTE 0
`define SSPW_CTRL2_SWRST 7
`define SSPW_CTRL2_ALAW 5
`define SSPW_FDI_TDM 6
`define SSPW_FDI_ASYNC 2
`define SSPW_FDI_RATE_LO 0
`define SSPW_TXP_BANK 3
`define SSPW_WD_KEY 5'h0a
`define SSPW_QUIET_MU 8'h7f
`define SSPW_QUIET_A 8'h55
`define SSPW_SRC_FILTER 2'h1
`define SSPW_SRC_AUX 2'h2
`define SSPW_WD_TIME_MS 512
`define SSPW_FRAME_US 125
`define SSPW_WD_FRAMES ((`SSPW_WD_TIME_MS * 1000) / `SSPW_FRAME_US)
`define SSPW_WD_CNT_W 12
`define SSPW_MCLK_KHZ 4096
`define SSPW_DIV_128 (`SSPW_MCLK_KHZ / 128)
`define SSPW_DIV_256 (`SSPW_MCLK_KHZ / 256)
`endif

// ---- include/sspw_pkg.sv ----
// types of the strobed serial port
package sspw_pkg;
   typedef enum logic [2:0] {
      SSPW_IDLE = 3'b001,
      SSPW_SLOT = 3'b010,
      SSPW_HOLD = 3'b100
   } sspw_slot_e;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] digital_interface_unit;
      logic [7:0] wdog;
      logic [7:0] txp;
      logic [7:0] rxp;
      logic [7:0] rdata;
      logic clk_s1;
      logic clk_s2;
      logic clk_d;
      logic stb_s1;
      logic stb_s2;
      logic stb_d;
      logic din_s1;
      logic din_s2;
      logic mck_s1;
      logic mck_s2;
      sspw_slot_e st;
      logic [7:0] tx_sh;
      logic [7:0] stage;
      logic [7:0] rx_sh;
      logic [7:0] rx_hold;
      logic [7:0] rx_data;
      logic hold_vld;
      logic rx_vld;
      logic oe_n;
      logic [2:0] bit_cnt;
      logic [4:0] div_cnt;
      logic [11:0] wd_cnt;
      logic wd_out;
      logic wd_run;
      logic codec_pwr;
      logic ref_pwr;
      logic [2:0] drv_pwr;
      logic [2:0] drv_aux;
      logic mck_gate;
   } sspw_state_s;
endpackage

// ---- rtl/sspw_top.sv ----
// strobed serial voice port with watchdog, path power control and transmit fifo
// Operation
// [RQ1] below 512 kHz bit clock the outside supplies a 4.096 MHz master clock
// [RQ2] strobed mode carries only B-channel audio; receive channel select bit ignored
// [RQ3] active-high 8 kHz strobe marks one 8-bit slot for transmit and receive
// [RQ4] asynchronous mode: codes 00/01 give 128/256 kHz derived from master clock
// [RQ5] synchronous mode: applied bit clock drives the port directly at coded rates
// [RQ6] sample input on falling edge, drive output on rising edge, tri-state outside strobe
// [RQ7] valid strobe with no transmit path sends quiet code for the slot
// [RQ8] no frame latency synchronous, exactly one frame latency asynchronous
// [RQ9] transmit path select picks one source; bank bit set acts as all zero
// [RQ10] receive path register gives each output port filter or auxiliary source
// [RQ11] watchdog output high in power-up reset, low at release, timer starts
// [RQ12] watchdog advances on strobe falling edge and stalls without strobe
// [RQ13] correct key before 512 ms timeout restarts timer, output stays low
// [RQ14] missed or wrong key toggles watchdog output each interval end
// [RQ15] controller writes key with low five bits 01010, upper bits ignored
// [RQ16] software reset keeps only register port and watchdog alive until cleared
// [RQ17] either reset restores default control bits, mu-law, sections powered down
// [RQ18] each output driver powered and tri-stated per its receive path assignment
// [RQ19] codec powers with any path; auxiliary-only routing powers reference only
// [RQ20] default strobed mode tri-stated outside strobe; backplane mode stays tri-stated
// [RQ21] oscillator halted until power-down bit clears; master clock blocked if async
// [RQ22] full power-down: clear both paths, set power-down and asynchronous bits
// [RQ23] quiet code is negative zero of the active companding table
`timescale 1ns/1ps
`default_nettype none
`include "sspw_defines.svh"

module sspw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } sspw_fifo_s;
   sspw_fifo_s f_reg;
   sspw_fifo_s f_next;
   logic push;
   logic pull;

   assign in_ready_o = f_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid_o = f_reg.cnt != '0;
   assign out_data_o = f_reg.mem[f_reg.rp];
   assign push = in_valid_i & in_ready_o;
   assign pull = out_valid_o & out_ready_i;

   always_comb
   begin
      f_next = f_reg;
      if (push)
      begin
         f_next.mem[f_reg.wp] = in_data_i;
         f_next.wp = f_reg.wp + 1'b1;
      end
      if (pull)
      begin
         f_next.rp = f_reg.rp + 1'b1;
      end
      if (push && !pull)
      begin
         f_next.cnt = f_reg.cnt + 1'b1;
      end
      else if (pull && !push)
      begin
         f_next.cnt = f_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         f_reg <= '0;
      end
      else
      begin
         f_reg <= f_next;
      end
   end
endmodule

module sspw_top (
   // clock and power-up reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // serial link
   input wire logic clock_input_pin_i,
   input wire logic slot_strobe_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_n_o,
   input wire logic master_clock_pin_i,
   output logic master_clock_gated_o,
   // transmit samples
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // received samples
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   // watchdog and power
   output logic watchdog_out_o,
   output logic codec_pwr_o,
   output logic ref_bias_pwr_o,
   output logic [2:0] driver_pwr_o,
   output logic [2:0] driver_aux_o
);
   sspw_pkg::sspw_state_s s_reg;
   sspw_pkg::sspw_state_s s_next;

   logic clk_rise;
   logic clk_fall;
   logic stb_rise;
   logic stb_fall;
   logic async_sel;
   logic osc_run;
   logic soft_rst;
   logic port_en;
   logic [4:0] div_last;
   logic [4:0] div_mid;
   logic bit_rise;
   logic bit_fall;
   logic [7:0] quiet;
   logic tx_active;
   logic slot_start;
   logic pop;
   logic [7:0] tx_byte;
   logic wd_kick;
   logic wd_expire;
   logic [7:0] fifo_data;
   logic fifo_valid;

   function automatic logic [7:0] sspw_quiet(input logic alaw);
      sspw_quiet = alaw ? `SSPW_QUIET_A : `SSPW_QUIET_MU;
   endfunction

   function automatic logic [2:0] sspw_tx_eff(input logic [7:0] txp);
      sspw_tx_eff = txp[`SSPW_TXP_BANK] ? 3'h0 : txp[2:0];
   endfunction

   sspw_fifo #(
      .WIDTH(8),
      .DEPTH(16)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_data_i(tx_data_i),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop)
   );

   assign clk_rise = s_reg.clk_s2 & ~s_reg.clk_d;
   assign clk_fall = ~s_reg.clk_s2 & s_reg.clk_d;
   assign stb_rise = s_reg.stb_s2 & ~s_reg.stb_d;
   assign stb_fall = ~s_reg.stb_s2 & s_reg.stb_d;
   assign async_sel = s_reg.digital_interface_unit[`SSPW_FDI_ASYNC];
   // oscillator and internal bit clock only run once power-down is cleared
   assign osc_run = async_sel & ~s_reg.ctrl1[`SSPW_CTRL1_PD]; // [RQ21]
   assign soft_rst = s_reg.ctrl2[`SSPW_CTRL2_SWRST];
   // backplane mode is not built here, so its stream stays tri-stated
   assign port_en = ~soft_rst & ~s_reg.digital_interface_unit[`SSPW_FDI_TDM]; // [RQ16] [RQ20]
   assign div_last = s_reg.digital_interface_unit[`SSPW_FDI_RATE_LO] ? 5'(`SSPW_DIV_256 - 1) :
                     5'(`SSPW_DIV_128 - 1); // [RQ4]
   assign div_mid = div_last >> 1;
   assign bit_rise = async_sel ? (osc_run & clk_rise & (s_reg.div_cnt == div_last)) :
                     clk_rise; // [RQ4] [RQ5]
   assign bit_fall = async_sel ? (osc_run & clk_rise & (s_reg.div_cnt == div_mid)) :
                     clk_fall; // [RQ5]
   assign quiet = sspw_quiet(s_reg.ctrl2[`SSPW_CTRL2_ALAW]); // [RQ23]
   assign tx_active = sspw_tx_eff(s_reg.txp) != 3'h0; // [RQ9]
   // the strobe alone places the slot; the channel select bit is never read
   assign slot_start = (s_reg.st == sspw_pkg::SSPW_IDLE) & stb_rise & port_en; // [RQ2] [RQ3]
   assign pop = slot_start & tx_active & ~s_reg.ctrl1[`SSPW_CTRL1_TXMUTE] & fifo_valid;
   assign tx_byte = pop ? fifo_data : quiet; // [RQ7]
   assign wd_kick = reg_wr_i & (reg_addr_i == `SSPW_ADDR_WDOG) &
                    (reg_wdata_i[4:0] == `SSPW_WD_KEY); // [RQ13] [RQ15]
   assign wd_expire = stb_fall & (s_reg.wd_cnt == `SSPW_WD_CNT_W'(`SSPW_WD_FRAMES - 1));

   assign reg_rdata_o = s_reg.rdata;
   assign dout_o = s_reg.tx_sh[7];
   assign dout_oe_n_o = s_reg.oe_n;
   assign master_clock_gated_o = s_reg.mck_gate;
   assign rx_data_o = s_reg.rx_data;
   assign rx_valid_o = s_reg.rx_vld;
   assign watchdog_out_o = s_reg.wd_out;
   assign codec_pwr_o = s_reg.codec_pwr;
   assign ref_bias_pwr_o = s_reg.ref_pwr;
   assign driver_pwr_o = s_reg.drv_pwr;
   assign driver_aux_o = s_reg.drv_aux;

   always_comb
   begin
      logic filt_used;
      logic aux_used;
      logic [1:0] src;
      filt_used = 1'b0;
      aux_used = 1'b0;
      src = 2'h0;
      s_next = s_reg;
      s_next.rx_vld = 1'b0;
      // pin synchronisers
      s_next.clk_s1 = clock_input_pin_i;
      s_next.clk_s2 = s_reg.clk_s1;
      s_next.clk_d = s_reg.clk_s2;
      s_next.stb_s1 = slot_strobe_i;
      s_next.stb_s2 = s_reg.stb_s1;
      s_next.stb_d = s_reg.stb_s2;
      s_next.din_s1 = din_i;
      s_next.din_s2 = s_reg.din_s1;
      s_next.mck_s1 = master_clock_pin_i;
      s_next.mck_s2 = s_reg.mck_s1;
      s_next.mck_gate = s_reg.mck_s2 & ~async_sel & ~s_reg.ctrl1[`SSPW_CTRL1_PD]; // [RQ21]

      // register port; while in software reset only ctrl2 and watchdog take writes, ctrl2 holding just its reset bit until a write clears it, all registers still read
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `SSPW_ADDR_CTRL1: s_next.rdata = s_reg.ctrl1;
            `SSPW_ADDR_CTRL2: s_next.rdata = s_reg.ctrl2;
            `SSPW_ADDR_FDI: s_next.rdata = s_reg.digital_interface_unit;
            `SSPW_ADDR_WDOG: s_next.rdata = s_reg.wdog;
            `SSPW_ADDR_TXP: s_next.rdata = s_reg.txp;
            `SSPW_ADDR_RXP: s_next.rdata = s_reg.rxp;
            default: s_next.rdata = 8'h00;
         endcase
      end
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            `SSPW_ADDR_CTRL1: if (!soft_rst) s_next.ctrl1 = reg_wdata_i & `SSPW_CTRL1_MASK;
            `SSPW_ADDR_CTRL2: s_next.ctrl2 = reg_wdata_i & `SSPW_CTRL2_MASK; // [RQ16]
            `SSPW_ADDR_FDI: if (!soft_rst) s_next.digital_interface_unit = reg_wdata_i & `SSPW_FDI_MASK;
            `SSPW_ADDR_WDOG: s_next.wdog = reg_wdata_i & `SSPW_WDOG_MASK;
            `SSPW_ADDR_TXP: if (!soft_rst) s_next.txp = reg_wdata_i & `SSPW_TXP_MASK;
            `SSPW_ADDR_RXP: if (!soft_rst) s_next.rxp = reg_wdata_i & `SSPW_RXP_MASK;
            default: s_next.rdata = s_next.rdata;
         endcase
      end
      if (soft_rst)
      begin
         // defaults held for as long as the bit stays set
         s_next.ctrl1 = `SSPW_CTRL1_RST; // [RQ17]
         s_next.digital_interface_unit = `SSPW_FDI_RST;
         s_next.txp = `SSPW_TXP_RST;
         s_next.rxp = `SSPW_RXP_RST;
         if (s_next.ctrl2[`SSPW_CTRL2_SWRST])
         begin
            s_next.ctrl2 = 8'h80;
         end
      end

      // internal bit clock realigned to each strobe
      if (!osc_run || stb_rise)
      begin
         s_next.div_cnt = 5'h00; // [RQ4]
      end
      else if (clk_rise)
      begin
         s_next.div_cnt = (s_reg.div_cnt == div_last) ? 5'h00 : s_reg.div_cnt + 5'h01;
      end

      // slot sequencer
      unique case (s_reg.st)
         sspw_pkg::SSPW_IDLE:
         begin
            s_next.oe_n = 1'b1; // [RQ6]
            if (slot_start)
            begin
               s_next.st = sspw_pkg::SSPW_SLOT;
               s_next.oe_n = 1'b0;
               s_next.bit_cnt = 3'h0;
               if (async_sel)
               begin
                  // one frame held back: last slot's byte goes out now
                  s_next.tx_sh = s_reg.stage; // [RQ8]
                  s_next.stage = tx_byte;
                  s_next.rx_data = s_reg.rx_hold;
                  s_next.rx_vld = s_reg.hold_vld & s_reg.codec_pwr;
                  s_next.hold_vld = 1'b0;
               end
               else
               begin
                  s_next.tx_sh = tx_byte; // [RQ8]
               end
            end
         end
         sspw_pkg::SSPW_SLOT:
         begin
            if (!s_reg.stb_s2 || !port_en)
            begin
               s_next.st = sspw_pkg::SSPW_IDLE;
               s_next.oe_n = 1'b1; // [RQ6]
            end
            else
            begin
               if (bit_rise)
               begin
                  s_next.tx_sh = {s_reg.tx_sh[6:0], 1'b0}; // [RQ6]
               end
               if (bit_fall)
               begin
                  s_next.rx_sh = {s_reg.rx_sh[6:0], s_reg.din_s2}; // [RQ6]
                  s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
                  if (s_reg.bit_cnt == 3'h7)
                  begin
                     s_next.st = sspw_pkg::SSPW_HOLD;
                     if (s_reg.ctrl1[`SSPW_CTRL1_RXMUTE])
                     begin
                        s_next.rx_sh = quiet;
                     end
                     if (async_sel)
                     begin
                        s_next.rx_hold = s_next.rx_sh;
                        s_next.hold_vld = 1'b1;
                     end
                     else
                     begin
                        s_next.rx_data = s_next.rx_sh;
                        s_next.rx_vld = s_reg.codec_pwr;
                     end
                  end
               end
            end
         end
         sspw_pkg::SSPW_HOLD:
         begin
            if (!s_reg.stb_s2 || !port_en)
            begin
               s_next.st = sspw_pkg::SSPW_IDLE;
               s_next.oe_n = 1'b1;
            end
         end
      endcase

      // watchdog, unaffected by software reset
      if (!s_reg.wd_run)
      begin
         s_next.wd_run = 1'b1;
         s_next.wd_out = 1'b0; // [RQ11]
         s_next.wd_cnt = '0;
      end
      else if (wd_kick)
      begin
         s_next.wd_cnt = '0; // [RQ13]
         s_next.wd_out = 1'b0;
      end
      else if (wd_expire)
      begin
         s_next.wd_cnt = '0;
         s_next.wd_out = ~s_reg.wd_out; // [RQ14]
      end
      else if (stb_fall)
      begin
         s_next.wd_cnt = s_reg.wd_cnt + 1'b1; // [RQ12]
      end

      // path driven power control
      for (int i = 0; i < 3; i++)
      begin
         src = s_reg.rxp[2*i +: 2]; // [RQ10]
         s_next.drv_pwr[i] = (src == `SSPW_SRC_FILTER) || (src == `SSPW_SRC_AUX); // [RQ18]
         s_next.drv_aux[i] = src == `SSPW_SRC_AUX;
         filt_used = filt_used | (src == `SSPW_SRC_FILTER);
         aux_used = aux_used | (src == `SSPW_SRC_AUX);
      end
      s_next.codec_pwr = tx_active | filt_used; // [RQ19]
      s_next.ref_pwr = tx_active | filt_used | aux_used; // [RQ19]
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         s_reg <= '0;
         s_reg.ctrl1 <= `SSPW_CTRL1_RST; // [RQ17]
         s_reg.ctrl2 <= `SSPW_CTRL2_RST;
         s_reg.digital_interface_unit <= `SSPW_FDI_RST;
         s_reg.wdog <= `SSPW_WDOG_RST;
         s_reg.txp <= `SSPW_TXP_RST;
         s_reg.rxp <= `SSPW_RXP_RST;
         s_reg.st <= sspw_pkg::SSPW_IDLE;
         s_reg.oe_n <= 1'b1;
         s_reg.wd_out <= 1'b1; // [RQ11]
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   oe_idle_a: assert property (!s_reg.stb_s2 && $past(!s_reg.stb_s2) |-> dout_oe_n_o) // [RQ6]
      else $error("output driven outside strobe");
   quiet_fill_a: assert property (slot_start && !tx_active && !async_sel |=> // [RQ7]
      s_reg.tx_sh == $past(quiet))
      else $error("quiet code not loaded");
   bank_ignore_a: assert property (s_reg.txp[`SSPW_TXP_BANK] |-> !pop) // [RQ9]
      else $error("bank setting drained fifo");
   wd_release_a: assert property ($past(sys_rst_i) |-> // [RQ11]
      watchdog_out_o ##1 !watchdog_out_o)
      else $error("watchdog not low after reset release");
   wd_kick_a: assert property (wd_kick && s_reg.wd_run |=> // [RQ13]
      s_reg.wd_cnt == '0 && !watchdog_out_o)
      else $error("key did not restart watchdog");
   wd_toggle_a: assert property (wd_expire && !wd_kick && s_reg.wd_run |=> // [RQ14]
      watchdog_out_o != $past(watchdog_out_o))
      else $error("watchdog did not toggle at interval end");
   wd_stall_a: assert property (!stb_fall && !wd_kick && s_reg.wd_run |=> // [RQ12]
      $stable(s_reg.wd_cnt))
      else $error("watchdog counted without strobe");
   soft_rst_a: assert property (soft_rst |=> s_reg.txp == '0 && s_reg.rxp == '0 && // [RQ16]
      s_reg.ctrl1 == `SSPW_CTRL1_RST && dout_oe_n_o)
      else $error("software reset left section active");
   power_off_a: assert property ((s_reg.txp == '0 && s_reg.rxp == '0) [*2] |-> // [RQ19]
      !codec_pwr_o && !ref_bias_pwr_o && driver_pwr_o == '0)
      else $error("sections powered with no path");
   async_lat_a: assert property (rx_valid_o && async_sel |-> $past(slot_start)) // [RQ8]
      else $error("async receive not delayed to slot start");

   sync_slot_c: cover property (s_reg.st == sspw_pkg::SSPW_HOLD && !async_sel && rx_valid_o);
   async_slot_c: cover property (rx_valid_o && async_sel);
   wd_expire_c: cover property (wd_expire && !wd_kick);
   fifo_full_c: cover property (tx_valid_i && !tx_ready_o);
endmodule
`default_nettype wire

// ---- sim/sspw_link_model.sv ----
// far-side transceiver model: bit clock, slot strobe and serial data
`timescale 1ns/1ps
`default_nettype none
module sspw_link_model (
   // link pins
   output logic cin_o,
   output logic stb_o,
   output logic din_o,
   input wire logic dout_i,
   input wire logic oe_n_i
);
   logic mclk_run = 1'b0;
   logic cin_free = 1'b0;
   logic cin_slot = 1'b0;
   logic stb_drv = 1'b0;
   logic din_drv = 1'b0;
   logic [7:0] cap;
   int oe_low;
   assign cin_o = mclk_run ? cin_free : cin_slot;
   assign stb_o = stb_drv;
   assign din_o = din_drv;
   // master clock runs free only in asynchronous mode
   always #122 cin_free = ~cin_free;
   // bit clock rises with the strobe and stands still between slots
   task automatic frame(input logic [7:0] d, input int half);
      begin
         cap = 8'h00;
         oe_low = 0;
         stb_drv = 1'b1;
         for (int i = 7; i >= 0; i--)
         begin
            din_drv = d[i];
            cin_slot = 1'b1;
            #(half);
            cin_slot = 1'b0;
            // sample halfway through the low phase, clear of sync latency
            #(half / 2);
            // an undriven line reads as the inverse of its last level
            cap[i] = (oe_n_i === 1'b0) ? dout_i : ~dout_i;
            if (oe_n_i === 1'b0) oe_low++;
            #(half - half / 2);
         end
         stb_drv = 1'b0;
         // released line must not keep its last level
         din_drv = ~din_drv;
         #(8 * half);
      end
   endtask
   task automatic pulses(input int n);
      repeat (n)
      begin
         stb_drv = 1'b1;
         #125;
         stb_drv = 1'b0;
         #125;
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/sspw_top_test.sv ----
// self-checking bench of the strobed serial port
`timescale 1ns/1ps
`default_nettype none
module sspw_top_test;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic master_clock_pin_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic tx_valid_i = 1'b0;
   logic [7:0] reg_rdata_o, rx_data_o;
   logic clock_input_pin_i, slot_strobe_i, din_i, dout_o, dout_oe_n_o;
   logic master_clock_gated_o, tx_ready_o, rx_valid_o, watchdog_out_o;
   logic codec_pwr_o, ref_bias_pwr_o;
   logic [2:0] driver_pwr_o, driver_aux_o;
   logic [7:0] rx_last = 8'h00;
   logic mg_d = 1'b0;
   int mg_cnt = 0;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [7:0] ra [7] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
   logic [7:0] rm [7] = '{8'he7, 8'h3c, 8'h7f, 8'h1f, 8'h0f, 8'hff, 8'h00};

   sspw_top dut (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .clock_input_pin_i, .slot_strobe_i, .din_i, .dout_o, .dout_oe_n_o,
      .master_clock_pin_i, .master_clock_gated_o, .tx_data_i, .tx_valid_i, .tx_ready_o,
      .rx_data_o, .rx_valid_o, .watchdog_out_o, .codec_pwr_o, .ref_bias_pwr_o,
      .driver_pwr_o, .driver_aux_o);
   sspw_link_model link (.cin_o(clock_input_pin_i), .stb_o(slot_strobe_i), .din_o(din_i),
      .dout_i(dout_o), .oe_n_i(dout_oe_n_o));

   always #25 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) master_clock_pin_i <= ~master_clock_pin_i;
   always @(posedge clk_sys_i)
   begin
      if (rx_valid_o === 1'b1) rx_last <= rx_data_o;
      mg_d <= master_clock_gated_o;
      if (master_clock_gated_o === 1'b1 && mg_d === 1'b0) mg_cnt <= mg_cnt + 1;
   end

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_i = 1'b0;
      idle(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
      chk("rdata", reg_rdata_o, exp);
   endtask
   task automatic push(input logic [7:0] d);
      @(negedge clk_sys_i);
      tx_data_i = d;
      tx_valid_i = 1'b1;
      chk("tx_ready", tx_ready_o, 8'h01);
      @(negedge clk_sys_i);
      tx_valid_i = 1'b0;
   endtask
   task automatic do_reset;
      @(negedge clk_sys_i);
      sys_rst_i = 1'b1;
      idle(8);
      chk("wdog", watchdog_out_o, 8'h01);
      sys_rst_i = 1'b0;
      idle(2);
      chk("wdog", watchdog_out_o, 8'h00);
   endtask
   // oel is how many of the 8 bit samples must see the output driven
   task automatic slot(input logic [7:0] d, input int half, input logic [7:0] exp, input int oel);
      link.frame(d, half);
      if (oel > 0) chk("dout", link.cap, exp);
      chk("oe_low", 8'(link.oe_low), 8'(oel));
      chk("oe_n", dout_oe_n_o, 8'h01);
   endtask
   task automatic wdc(input int n, input logic [7:0] e);
      link.pulses(n);
      idle(8);
      chk("wdog", watchdog_out_o, e);
   endtask
   task automatic mgc(input logic [7:0] e);
      int m0;
      m0 = mg_cnt;
      idle(40);
      chk("mclk_gate", 8'(mg_cnt != m0), e);
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // longest legal run is about 3.5 ms, mostly watchdog strobes
   initial
   begin
      #5ms;
      n_mismatch++;
      finish_test;
   end

   initial
   begin
      do_reset;
      for (int i = 0; i < 7; i++)
      begin
         rd(ra[i], (i == 0) ? 8'h80 : 8'h00);
         wr(ra[i], (i == 1) ? 8'h7f : 8'hff);
         rd(ra[i], rm[i]);
      end
      do_reset;
      rd(8'h10, 8'h00);
      wdc(2000, 8'h00);
      wr(8'h11, 8'h0b);
      wdc(2095, 8'h00);
      wdc(1, 8'h01);
      wr(8'h11, 8'hea);
      chk("wdog", watchdog_out_o, 8'h00);
      wdc(4095, 8'h00);
      wdc(1, 8'h01);
      wdc(4095, 8'h01);
      wdc(1, 8'h00);
      slot(8'h3c, 200, 8'h7f, 8);
      wr(8'h12, 8'h09);
      slot(8'h3c, 200, 8'h7f, 8);
      chk("codec", codec_pwr_o, 8'h00);
      wr(8'h0f, 8'h20);
      slot(8'h3c, 200, 8'h55, 8);
      wr(8'h0f, 8'h00);
      wr(8'h13, 8'h21);
      chk("drv_pwr", driver_pwr_o, 8'h05);
      chk("drv_aux", driver_aux_o, 8'h04);
      chk("codec", codec_pwr_o, 8'h01);
      wr(8'h13, 8'h20);
      chk("codec", codec_pwr_o, 8'h00);
      chk("ref", ref_bias_pwr_o, 8'h01);
      chk("drv_pwr", driver_pwr_o, 8'h04);
      wr(8'h12, 8'h01);
      wr(8'h0e, 8'h84);
      for (int i = 0; i < 16; i++) push({i[3:0], ~i[3:0]});
      chk("tx_ready", tx_ready_o, 8'h00);
      for (int i = 0; i < 16; i++)
      begin
         wr(8'h10, 8'(i % 4));
         slot({~i[3:0], i[3:0]}, 200, {i[3:0], ~i[3:0]}, 8);
         chk("rx", rx_last, {~i[3:0], i[3:0]});
      end
      push(8'h11);
      wr(8'h0e, 8'h87);
      slot(8'h3c, 200, 8'h7f, 8);
      chk("rx", rx_last, 8'h7f);
      wr(8'h0e, 8'h84);
      slot(8'h96, 200, 8'h11, 8);
      chk("rx", rx_last, 8'h96);
      wr(8'h0f, 8'h80);
      rd(8'h0f, 8'h80);
      wr(8'h12, 8'h01);
      rd(8'h12, 8'h00);
      chk("codec", codec_pwr_o, 8'h00);
      slot(8'h3c, 200, 8'h00, 0);
      wr(8'h0f, 8'h00);
      wr(8'h10, 8'h40);
      slot(8'h3c, 200, 8'h00, 0);
      mgc(8'h00);
      wr(8'h0e, 8'h00);
      wr(8'h10, 8'h00);
      mgc(8'h01);
      wr(8'h12, 8'h01);
      link.mclk_run = 1'b1;
      for (int r = 0; r < 2; r++)
      begin
         wr(8'h10, 8'h04 | 8'(r));
         mgc(8'h00);
         push(8'ha1 + 8'(r));
         link.frame(8'h5a + 8'(r), r ? 1953 : 3906);
         slot(8'h33, r ? 1953 : 3906, 8'ha1 + 8'(r), 8);
         chk("rx", rx_last, 8'h5a + 8'(r));
      end
      wr(8'h12, 8'h00);
      wr(8'h13, 8'h00);
      wr(8'h0e, 8'h80);
      chk("codec", codec_pwr_o, 8'h00);
      chk("ref", ref_bias_pwr_o, 8'h00);
      chk("drv_pwr", driver_pwr_o, 8'h00);
      finish_test;
   end
endmodule
`default_nettype wire
